// ### ddct_consts.vh
// Command codes, mode fields and timing defaults for the DDR command timing core
`ifndef DDCT_CONSTS_VH
`define DDCT_CONSTS_VH
// ****************************************
// Command codes on the command pins
// ****************************************
`define DDCT_CMD_NOP    3'h0
`define DDCT_CMD_ACT    3'h1
`define DDCT_CMD_READ   3'h2
`define DDCT_CMD_WRITE  3'h3
`define DDCT_CMD_PRE    3'h4
`define DDCT_CMD_REF    3'h5
`define DDCT_CMD_MRS    3'h6
`define DDCT_CMD_WRITEA 3'h7
// ****************************************
// Mode register burst length field
// ****************************************
`define DDCT_BL_LSB     0
`define DDCT_BL_MSB     2
`define DDCT_BL_2       3'h1
`define DDCT_BL_4       3'h2
`define DDCT_BL_8       3'h3
`define DDCT_BL_RESET   3'h1
// ****************************************
// Timing counts in clocks, 200 MHz grade
// ****************************************
`define DDCT_T_RFC      14
`define DDCT_T_RCDRD    4
`define DDCT_T_RCDWR    2
`define DDCT_T_MRD      2
`define DDCT_T_WR2RD_IL 2
`define DDCT_CAS_LAT    3
`endif

// ### ddct_mem.v
// Byte-enabled storage array with registered read data
`timescale 1ns/1ps
module ddct_mem #(
  parameter AW = 8,
  parameter DW = 32
) (
  input  wire            sys_clk_in,
  input  wire            wr_en_in,
  input  wire [AW-1:0]   wr_addr_in,
  input  wire [DW-1:0]   wr_data_in,
  input  wire [DW/8-1:0] wr_be_in,
  input  wire [AW-1:0]   rd_addr_in,
  output reg  [DW-1:0]   rd_data_out
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];
  integer i;

  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      for (i = 0; i < DW/8; i = i + 1) begin
        if (wr_be_in[i]) begin
          mem_q[wr_addr_in][i*8 +: 8] <= wr_data_in[i*8 +: 8];
        end
      end
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule

// ### ddct_core.v
// DDR DRAM command decode, write burst with read interrupt, read pipeline and timing checks
`timescale 1ns/1ps
`include "ddct_consts.vh"
// Function
// - Normal writes store an even number of data words.
// - A read to any bank may cut short a write burst.
// - Write words presented before the interrupting read are stored.
// - Strobe is ignored for write words cut off by the read.
// - Read interrupting write allowed only at 200 or 166 MHz.
module ddct_core #(
  parameter ROW_W    = 2,
  parameter COL_W    = 4,
  parameter DW       = 16,
  parameter CAS_LAT  = `DDCT_CAS_LAT,
  parameter T_RFC    = `DDCT_T_RFC,
  parameter T_RCDRD  = `DDCT_T_RCDRD,
  parameter T_RCDWR  = `DDCT_T_RCDWR,
  parameter T_MRD    = `DDCT_T_MRD,
  parameter T_WR2RD  = `DDCT_T_WR2RD_IL
) (
  input  wire              sys_clk_in,
  input  wire              rst_in,
  input  wire [2:0]        cmd_in,
  input  wire [1:0]        bank_in,
  input  wire [ROW_W-1:0]  row_in,
  input  wire [COL_W-1:0]  col_in,
  input  wire [2*DW-1:0]   dq_in,
  input  wire [DW/4-1:0]   dm_in,
  input  wire              dqs_in,
  input  wire              interrupt_ok_in,
  output reg  [2*DW-1:0]   dq_out,
  output reg               dq_oe_n_out,
  output reg               dqs_out,
  output reg               timing_violation_out,
  output reg               cmd_refused_out
);
  // ****************************************
  // Widths
  // ****************************************
  localparam PW  = 3 + 2 + ROW_W + COL_W + 2*DW + DW/4 + 2;
  localparam CPW = COL_W - 1;
  localparam AW  = 2 + ROW_W + CPW;

  // Saturating count so a long-idle bank never wraps back to too soon
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      sat_inc = (v == 8'hff) ? v : (v + 8'h01);
    end
  endfunction

  // Elapsed clocks is since+1; short when below the limit
  function too_soon;
    input [7:0]  since;
    input [31:0] limit;
    begin
      too_soon = ({24'h000000, since} + 32'h1) < limit;
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg  [PW-1:0] pin_meta_q;
  reg  [PW-1:0] pin_q;
  always @(posedge sys_clk_in) begin
    pin_meta_q <= {cmd_in, bank_in, row_in, col_in, dq_in, dm_in, dqs_in, interrupt_ok_in};
    pin_q      <= pin_meta_q;
  end

  wire [2:0]       cmd;
  wire [1:0]       bank;
  wire [ROW_W-1:0] row;
  wire [COL_W-1:0] col;
  wire [2*DW-1:0]  dq;
  wire [DW/4-1:0]  dm;
  wire             dqs;
  wire             il_ok;
  assign {cmd, bank, row, col, dq, dm, dqs, il_ok} = pin_q;

  // ****************************************
  // Command state
  // ****************************************
  reg  [ROW_W-1:0] open_row_q [0:3];
  reg  [7:0]       act_since_q [0:3];
  reg  [7:0]       hold_q;
  reg  [7:0]       wr_since_q;
  reg  [2:0]       bl_pairs_q;
  reg              wr_active_q;
  reg  [2:0]       wr_left_q;
  reg  [AW-1:0]    wr_addr_q;
  reg              rd_active_q;
  reg  [2:0]       rd_left_q;
  reg  [AW-1:0]    rd_addr_q;
  reg  [CAS_LAT-1:0] rd_pipe_q;
  reg  [2*DW-1:0]  rd_data_q [0:CAS_LAT-1];
  wire [2*DW-1:0]  mem_rd_data;
  integer          b;
  integer          p;

  wire is_read  = (cmd == `DDCT_CMD_READ);
  wire is_write = (cmd == `DDCT_CMD_WRITE) || (cmd == `DDCT_CMD_WRITEA);
  wire is_cmd   = (cmd != `DDCT_CMD_NOP);
  // Cut-short only at the 200 or 166 MHz grades; elsewhere the read is turned away
  wire rd_cuts  = is_read && wr_active_q && il_ok;
  wire rd_refuse = is_read && wr_active_q && !il_ok;
  wire rd_go    = is_read && !rd_refuse;
  wire [AW-1:0] cmd_addr = {bank, open_row_q[bank], col[COL_W-1:1]};

  // Watches the far side's spacing; a slip only raises a sticky flag
  reg viol;
  always @* begin
    viol = 1'b0;
    if (is_cmd && hold_q != 8'h00) begin
      viol = 1'b1;
    end
    if (is_read && too_soon(act_since_q[bank], T_RCDRD)) begin
      viol = 1'b1;
    end
    if (is_write && too_soon(act_since_q[bank], T_RCDWR)) begin
      viol = 1'b1;
    end
    if (rd_cuts && too_soon(wr_since_q, T_WR2RD)) begin
      viol = 1'b1;
    end
    if (rd_refuse) begin
      viol = 1'b1;
    end
  end

  // Pairs land together, so a normal burst always stores an even count
  // Strobe counts only while the burst still runs and not in the cut cycle
  wire wr_take = wr_active_q && !rd_cuts && dqs;
  wire [DW/4-1:0] wr_be = ~dm;

  ddct_mem #(
    .AW (AW),
    .DW (2*DW)
  ) u_mem (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (wr_take),
    .wr_addr_in  (wr_addr_q),
    .wr_data_in  (dq),
    .wr_be_in    (wr_be),
    .rd_addr_in  (rd_addr_q),
    .rd_data_out (mem_rd_data)
  );

  // ****************************************
  // Sequencing
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (b = 0; b < 4; b = b + 1) begin
        open_row_q[b]  <= {ROW_W{1'b0}};
        act_since_q[b] <= 8'hff;
      end
      hold_q               <= 8'h00;
      wr_since_q           <= 8'hff;
      bl_pairs_q           <= 3'h1;
      wr_active_q          <= 1'b0;
      wr_left_q            <= 3'h0;
      wr_addr_q            <= {AW{1'b0}};
      rd_active_q          <= 1'b0;
      rd_left_q            <= 3'h0;
      rd_addr_q            <= {AW{1'b0}};
      timing_violation_out <= 1'b0;
      cmd_refused_out      <= 1'b0;
    end else begin
      cmd_refused_out <= rd_refuse;
      if (viol) begin
        timing_violation_out <= 1'b1;
      end
      for (b = 0; b < 4; b = b + 1) begin
        act_since_q[b] <= sat_inc(act_since_q[b]);
      end
      wr_since_q <= sat_inc(wr_since_q);
      if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
      case (cmd)
        `DDCT_CMD_ACT: begin
          open_row_q[bank]  <= row;
          act_since_q[bank] <= 8'h00;
        end
        `DDCT_CMD_REF: begin
          hold_q <= T_RFC[7:0] - 8'h01;
        end
        `DDCT_CMD_MRS: begin
          hold_q <= T_MRD[7:0] - 8'h01;
          case (col[`DDCT_BL_MSB:`DDCT_BL_LSB])
            `DDCT_BL_4: bl_pairs_q <= 3'h2;
            `DDCT_BL_8: bl_pairs_q <= 3'h4;
            default:    bl_pairs_q <= 3'h1;
          endcase
        end
        default: begin
        end
      endcase
      // Write burst, one pair per clock; a new write restarts it
      if (is_write) begin
        wr_active_q <= 1'b1;
        wr_left_q   <= bl_pairs_q;
        wr_addr_q   <= cmd_addr;
        wr_since_q  <= 8'h00;
      end else if (rd_cuts) begin
        wr_active_q <= 1'b0;
        wr_left_q   <= 3'h0;
      end else if (wr_active_q) begin
        wr_addr_q <= wr_addr_q + {{(AW-1){1'b0}}, 1'b1};
        wr_left_q <= wr_left_q - 3'h1;
        if (wr_left_q == 3'h1) begin
          wr_active_q <= 1'b0;
        end
      end
      // Read burst address walk
      if (rd_go) begin
        rd_active_q <= 1'b1;
        rd_left_q   <= bl_pairs_q;
        rd_addr_q   <= cmd_addr;
      end else if (rd_active_q) begin
        rd_addr_q <= rd_addr_q + {{(AW-1){1'b0}}, 1'b1};
        rd_left_q <= rd_left_q - 3'h1;
        if (rd_left_q == 3'h1) begin
          rd_active_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Read latency pipeline and pin drive
  // ****************************************
  // Array read adds a clock, so the pipe holds CAS_LAT-1 more stages
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_pipe_q   <= {CAS_LAT{1'b0}};
      dq_out      <= {(2*DW){1'b0}};
      dq_oe_n_out <= 1'b1;
      dqs_out     <= 1'b0;
      for (p = 0; p < CAS_LAT; p = p + 1) begin
        rd_data_q[p] <= {(2*DW){1'b0}};
      end
    end else begin
      rd_pipe_q    <= {rd_pipe_q[CAS_LAT-2:0], rd_active_q};
      rd_data_q[0] <= mem_rd_data;
      for (p = 1; p < CAS_LAT; p = p + 1) begin
        rd_data_q[p] <= rd_data_q[p-1];
      end
      dq_out      <= rd_pipe_q[CAS_LAT-1] ? rd_data_q[CAS_LAT-2] : {(2*DW){1'b0}};
      dq_oe_n_out <= ~rd_pipe_q[CAS_LAT-1];
      dqs_out     <= rd_pipe_q[CAS_LAT-1];
    end
  end
endmodule

// ### ddct_core_asserts.sv
// Port assertions for the DDR command timing core
`timescale 1ns/1ps
`include "ddct_consts.vh"
module ddct_core_asserts #(
  parameter DW = 16
) (
  input wire            sys_clk_in,
  input wire            rst_in,
  input wire [2:0]      cmd_in,
  input wire            interrupt_ok_in,
  input wire [2*DW-1:0] dq_out,
  input wire            dq_oe_n_out,
  input wire            dqs_out,
  input wire            timing_violation_out,
  input wire            cmd_refused_out
);
  // ********
  // Checks, windows allow for the pin synchronisers
  // ********
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  chk_read_answer: assert property ((cmd_in == `DDCT_CMD_READ && interrupt_ok_in)
    |-> ##[5:8] (dqs_out && !dq_oe_n_out)) else $error("read not answered");
  chk_refuse_flag: assert property (cmd_refused_out |-> ##[0:1] timing_violation_out)
    else $error("refusal not flagged");
  chk_refuse_quiet: assert property (cmd_refused_out |-> dq_oe_n_out [*6])
    else $error("refused read drove data");
  chk_idle_bus: assert property (dq_oe_n_out |-> (!dqs_out && dq_out == '0))
    else $error("bus active while released");
  chk_flag_sticky: assert property (timing_violation_out |=> timing_violation_out)
    else $error("violation flag dropped");
  chk_ok_no_refuse: assert property (interrupt_ok_in [*6] |-> !cmd_refused_out)
    else $error("read refused at legal rate");
  cover property (cmd_in == `DDCT_CMD_WRITE ##2 cmd_in == `DDCT_CMD_READ);
  cover property (cmd_refused_out);
  cover property ($rose(dqs_out));
endmodule
bind ddct_core ddct_core_asserts #(.DW(DW)) u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .cmd_in(cmd_in), .interrupt_ok_in(interrupt_ok_in), .dq_out(dq_out),
  .dq_oe_n_out(dq_oe_n_out), .dqs_out(dqs_out), .timing_violation_out(timing_violation_out),
  .cmd_refused_out(cmd_refused_out));

// ### ddct_ctrl_model.sv
// Controller model driving the DDR command timing core pins
`timescale 1ns/1ps
`include "ddct_consts.vh"
module ddct_ctrl_model (
  input  wire         sys_clk_in,
  output logic [2:0]  cmd_out,
  output logic [1:0]  bank_out,
  output logic [1:0]  row_out,
  output logic [3:0]  col_out,
  output logic [31:0] dq_out,
  output logic [3:0]  dm_out,
  output logic        dqs_out
);
  // ********
  // Pin drivers
  // ********
  initial {cmd_out, bank_out, row_out, col_out, dq_out, dm_out, dqs_out} = '0;
  // Spacing is kept by idle clocks after each command
  // No self refresh or power-down exit is ever issued, so those waits hold
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, r, input logic [3:0] cl,
                     input int gap);
    @(posedge sys_clk_in);
    {cmd_out, bank_out, row_out, col_out} <= {c, b, r, cl};
    repeat (gap - 1) begin
      @(posedge sys_clk_in);
      // Released data toggles so a stale word can never pass
      {cmd_out, dqs_out, dq_out} <= {`DDCT_CMD_NOP, 1'b0, ~dq_out};
    end
  endtask
  // A cut burst drives msk on every word from the read onward
  task automatic wr(input logic [1:0] b, r, input logic [3:0] cl, input int n, cut,
                    input logic [3:0] msk, input logic [31:0] d [4]);
    cmd(`DDCT_CMD_WRITE, b, r, cl, 1);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      cmd_out <= (cut && i == 1) ? `DDCT_CMD_READ : `DDCT_CMD_NOP;
      {dq_out, dqs_out} <= {d[i], 1'b1};
      dm_out <= (cut && i > 0) ? msk : 4'h0;
    end
    cmd(`DDCT_CMD_NOP, b, r, cl, 12);
  endtask
endmodule

// ### ddr_dram_command_timing_bench.sv
// Self-checking bench for the DDR command timing core
`timescale 1ns/1ps
`include "ddct_consts.vh"
module ddr_dram_command_timing_bench;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        iok = 1'b1;
  wire  [2:0]  cmd;
  wire  [1:0]  bank, row;
  wire  [3:0]  col, dm;
  wire  [31:0] wdq, rdq;
  wire         wdqs, oe_n, rdqs, viol, refused;
  int          failures = 0;
  int          total_checks = 0;
  int          n_ref = 0;
  logic [31:0] exp_q [$];
  logic [31:0] sh [logic [6:0]];
  logic [31:0] d [4];
  logic [1:0]  rows [4];
  logic [3:0]  cols [4];
  always #12.5 sys_clk_in = ~sys_clk_in;
  ddct_core i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cmd_in(cmd), .bank_in(bank),
    .row_in(row), .col_in(col), .dq_in(wdq), .dm_in(dm), .dqs_in(wdqs), .interrupt_ok_in(iok),
    .dq_out(rdq), .dq_oe_n_out(oe_n), .dqs_out(rdqs), .timing_violation_out(viol),
    .cmd_refused_out(refused));
  ddct_ctrl_model i_ctrl (.sys_clk_in(sys_clk_in), .cmd_out(cmd), .bank_out(bank),
    .row_out(row), .col_out(col), .dq_out(wdq), .dm_out(dm), .dqs_out(wdqs));
  // ********
  // Helpers
  // ********
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, want, input string msg);
    total_checks++;
    if (got !== want) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  function automatic logic [6:0] key(input logic [1:0] b, r, input logic [3:0] cl, input int i);
    return {b, r, cl[3:1] + i[2:0]};
  endfunction
  task automatic note(input logic [1:0] b, r, input logic [3:0] cl, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(sh[key(b, r, cl, i)]);
  endtask
  task automatic rd(input logic [1:0] b, r, input logic [3:0] cl, input int n, gap);
    note(b, r, cl, n);
    i_ctrl.cmd(`DDCT_CMD_READ, b, r, cl, gap);
  endtask
  always @(posedge sys_clk_in) begin
    if (refused === 1'b1) n_ref++;
    if (rdqs === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected read data");
      else check(rdq, exp_q.pop_front(), "read data wrong");
      check(oe_n, 32'h0, "read pair not driven");
    end
  end
  // ********
  // Scenarios
  // ********
  initial begin
    void'($urandom(14776));
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    i_ctrl.cmd(`DDCT_CMD_REF, 0, 0, 0, `DDCT_T_RFC + 1);
    i_ctrl.cmd(`DDCT_CMD_MRS, 0, 0, 4'h1, `DDCT_T_MRD + 1);
    for (int b = 0; b < 4; b++) begin
      rows[b] = 2'($urandom_range(3));
      cols[b] = 4'($urandom_range(15));
      d[0] = $urandom;
      sh[key(b[1:0], rows[b], cols[b], 0)] = d[0];
      i_ctrl.cmd(`DDCT_CMD_ACT, b[1:0], rows[b], 0, `DDCT_T_RCDRD + 1);
      i_ctrl.wr(b[1:0], rows[b], cols[b], 1, 0, 4'h0, d);
    end
    for (int b = 0; b < 4; b++) rd(b[1:0], rows[b], cols[b], 1, (b == 3) ? 10 : 1);
    i_ctrl.cmd(`DDCT_CMD_MRS, 0, 0, 4'h3, `DDCT_T_MRD + 1);
    // Full burst first, then a masked cut and an unmasked cut
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) d[i] = $urandom;
      for (int i = 0; i < 4; i++) if (k == 0 || i == 0) sh[key(0, rows[0], 0, i)] = d[i];
      if (k > 0) note(0, rows[0], 0, 4);
      i_ctrl.wr(0, rows[0], 0, 4, k > 0, (k == 1) ? 4'hf : 4'h0, d);
      if (k == 0) rd(0, rows[0], 0, 4, 14);
    end
    check(viol, 0, "violation without cause");
    iok <= 1'b0;
    for (int i = 0; i < 4; i++) d[i] = $urandom;
    sh[key(0, rows[0], 0, 0)] = d[0];
    i_ctrl.wr(0, rows[0], 0, 4, 1, 4'hf, d);
    rd(0, rows[0], 0, 4, 14);
    check(n_ref, 1, "read not refused");
    check(viol, 1, "refusal not flagged");
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    check(viol, 0, "flag kept through reset");
    check(exp_q.size(), 0, "read data missing");
    report_and_stop();
  end
  // Run needs a few hundred clocks, so this only trips on a hang
  initial begin
    repeat (3000) @(posedge sys_clk_in);
    failures++;
    report_and_stop();
  end
endmodule
